// ===== logic/dsss_framer_pkg.sv
// Register map, field layout, reset values and types of the DSSS framer.
// Assumes MAC, modulator and framer all run on one symbol-rate clock.
//
// Summary of operation
// - Send sync header, length header, payload in order
// - Low octet first, each octet LSB first
// - Sync header is preamble then delimiter
// - Preamble is repeat count times two or four octets
// - Short pattern 0011 1111 0101 1001, written order
// - Delimiter detection marks receive frame alignment
// - Fixed mode receives without a length header
// - Fixed payload size omits the length header
// - Up to 128 octets: one-octet header, delimiter
// - 129 to 2048 octets: two-octet length header
// - One-octet header carries length minus one
// - Short header 0+7 bits, long 1+4+11 bits
// - All fields share one modulation output path
// - Coded stream passes interleaver before spreading
// - Fragments of 256, 384 and 512 symbols
// - Non power-of-two fragments drop out-of-range indices
// - 256: output M takes input bit-reversed M
// - 384: nine-bit reversal, keep values below 384
// - Repeat count zero to eight sets preamble
package dsss_framer_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFF     = 8'h00;
	localparam logic [ADDR_W-1:0] LENGTH_OFF   = 8'h04;
	localparam logic [ADDR_W-1:0] RX_MAX_OFF   = 8'h08;
	localparam logic [ADDR_W-1:0] DELIM_OFF    = 8'h0C;
	localparam logic [ADDR_W-1:0] LONG_PRE_OFF = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_OFF   = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_TX_START = 0;
	localparam int CTRL_LO       = 1;
	localparam int CTRL_HI       = 11;
	localparam int REP_LO        = 8;
	localparam int REP_HI        = 11;
	localparam int STAT_TX_BUSY  = 0;
	localparam int STAT_RX_BUSY  = 1;
	localparam int STAT_RX_ERR   = 2;
	localparam int STAT_LEN_LO   = 16;
	localparam int LEN_W         = 12;
	localparam int STAT_LEN_HI   = STAT_LEN_LO + LEN_W - 1;
	localparam int INTLV_IDX_W   = 9;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FRAG_256 = 2'b00,
		FRAG_384 = 2'b01,
		FRAG_512 = 2'b10
	} frag_e;

	typedef struct packed {
		logic [3:0] preamble_pattern_repeat_count;
		frag_e      frag;
		logic       long_hdr;
		logic       long_pre;
		logic       delimiter_present_flag;
		logic       fixed;
		logic       rx_en;
	} ctrl_s;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_PRE  = 3'b001,
		TX_SFD  = 3'b010,
		TX_PHR  = 3'b011,
		TX_PAY  = 3'b100
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_HUNT = 2'b01,
		RX_PHR  = 2'b10,
		RX_PAY  = 2'b11
	} rx_state_e;

	// ------------------------------------------------------------
	// Reset values and fixed patterns
	// ------------------------------------------------------------
	localparam ctrl_s CTRL_RST = '{
		preamble_pattern_repeat_count: 4'h1, frag: FRAG_256,
		long_hdr: 1'b0, long_pre: 1'b0, delimiter_present_flag: 1'b1,
		fixed: 1'b0, rx_en: 1'b0};
	localparam logic [3:0]       REP_MAX      = 4'h8;
	localparam logic [LEN_W-1:0] LEN_RST      = 12'h010;
	localparam logic [LEN_W-1:0] RX_MAX_RST   = 12'h800;
	localparam logic [LEN_W-1:0] SHORT_MAX    = 12'h080;
	localparam logic [7:0]       DELIM_RST    = 8'hA7;
	localparam logic [31:0]      LONG_PRE_RST = 32'h0000_0000;
	localparam logic [15:0]      SHORT_PREAMBLE_PATTERN = 16'h3F59;
	localparam logic [9:0]       FRAG_256_SYMS = 10'h100;
	localparam logic [9:0]       FRAG_384_SYMS = 10'h180;
	localparam logic [9:0]       FRAG_512_SYMS = 10'h200;

endpackage

// ===== logic/pruned_reverse_interleaver.sv
// Pruned bit-reversal interleaver for one coded fragment.
// Assumes the coder honours sym_ready_o and the spreader sym_valid_o.
`timescale 1ns/1ns
module pruned_reverse_interleaver #(
	parameter int IDX_W = dsss_framer_pkg::INTLV_IDX_W
) (
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  ce_i,
	// Configuration
	input  wire dsss_framer_pkg::frag_e frag_sel_i,
	// Coded symbols in
	input  wire logic                  sym_i,
	input  wire logic                  sym_valid_i,
	output logic                       sym_ready_o,
	// Interleaved symbols out
	output logic                       sym_o,
	output logic                       sym_valid_o,
	input  wire logic                  sym_ready_i
);
	import dsss_framer_pkg::*;

	logic [(1<<IDX_W)-1:0] mem_reg;
	logic [IDX_W:0]        idx_reg;
	logic                  drain_reg;
	logic [IDX_W-1:0]      rev_full;
	logic [IDX_W-1:0]      rev_short;
	logic [IDX_W-1:0]      n_idx;
	logic [IDX_W:0]        size;
	logic [IDX_W:0]        span;
	logic                  adv;

	// ------------------------------------------------------------
	// Index reversal
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < IDX_W; gi++) begin : g_rev
			assign rev_full[gi] = idx_reg[IDX_W-1-gi];
			if (gi < IDX_W - 1) begin : g_short
				assign rev_short[gi] = idx_reg[IDX_W-2-gi];
			end else begin : g_top
				assign rev_short[gi] = 1'b0;
			end
		end
	endgenerate

	always_comb begin
		case (frag_sel_i)
		FRAG_256: size = (IDX_W+1)'(FRAG_256_SYMS);
		FRAG_384: size = (IDX_W+1)'(FRAG_384_SYMS);
		default:  size = (IDX_W+1)'(FRAG_512_SYMS);
		endcase
	end

	assign span  = (frag_sel_i == FRAG_256) ? size : (IDX_W+1)'(1 << IDX_W);
	assign n_idx = (frag_sel_i == FRAG_256) ? rev_short : rev_full;
	assign adv   = !sym_valid_o || sym_ready_i;

	// ------------------------------------------------------------
	// Fill, then drain in reversed order
	// ------------------------------------------------------------
	// Pruned positions leave a bubble rather than a look-ahead search:
	// cheaper, and the spreader copes with valid gaps anyway.
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mem_reg     <= '0;
			idx_reg     <= '0;
			drain_reg   <= 1'b0;
			sym_ready_o <= 1'b1;
			sym_o       <= 1'b0;
			sym_valid_o <= 1'b0;
		end else if (ce_i) begin
			if (!drain_reg) begin
				if (sym_valid_i && sym_ready_o) begin
					mem_reg[idx_reg[IDX_W-1:0]] <= sym_i;
					if (idx_reg == size - 1'b1) begin
						idx_reg     <= '0;
						drain_reg   <= 1'b1;
						sym_ready_o <= 1'b0;
					end else begin
						idx_reg <= idx_reg + 1'b1;
					end
				end
			end else if (adv) begin
				if (idx_reg == span) begin
					idx_reg     <= '0;
					drain_reg   <= 1'b0;
					sym_ready_o <= 1'b1;
					sym_valid_o <= 1'b0;
				end else begin
					sym_valid_o <= ({1'b0, n_idx} < size);
					sym_o       <= mem_reg[n_idx];
					idx_reg     <= idx_reg + 1'b1;
				end
			end
		end
	end

endmodule

// ===== logic/dsss_ppdu_framer.sv
// DSSS PPDU framer: builds and parses frames, APB register slave.
// Assumes MAC, modulator and coder logic share clk_i; no synchronisers.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
module dsss_ppdu_framer (
	// Clock, reset, enable
	input  wire logic                              clk_i,
	input  wire logic                              reset_n_i,
	input  wire logic                              ce_i,
	// APB slave
	input  wire logic [dsss_framer_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic                              psel_i,
	input  wire logic                              penable_i,
	input  wire logic                              pwrite_i,
	input  wire logic [31:0]                       pwdata_i,
	output logic [31:0]                            prdata_o,
	output logic                                   pready_o,
	output logic                                   pslverr_o,
	// Transmit payload from MAC
	input  wire logic [7:0]                        tx_byte_i,
	input  wire logic                              tx_byte_valid_i,
	output logic                                   tx_byte_ready_o,
	output logic                                   tx_done_o,
	// Transmit bits to modulation chain
	output logic                                   tx_bit_o,
	output logic                                   tx_bit_valid_o,
	input  wire logic                              tx_bit_ready_i,
	// Receive bits from demodulator
	input  wire logic                              rx_bit_i,
	input  wire logic                              rx_bit_valid_i,
	// Receive payload to MAC
	output logic [7:0]                             rx_byte_o,
	output logic                                   rx_byte_valid_o,
	output logic                                   rx_sync_o,
	output logic                                   rx_end_o,
	// Coded symbols to interleaver and on to spreader
	input  wire logic                              coded_sym_i,
	input  wire logic                              coded_valid_i,
	output logic                                   coded_ready_o,
	output logic                                   intlv_sym_o,
	output logic                                   intlv_valid_o,
	input  wire logic                              intlv_ready_i
);
	import dsss_framer_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	ctrl_s            ctrl_reg;
	logic [LEN_W-1:0] len_reg;
	logic [LEN_W-1:0] rx_max_reg;
	logic [7:0]       delim_reg;
	logic [31:0]      long_pre_reg;
	logic             start_reg;
	logic             rx_err_reg;
	logic             err_pulse_reg;
	logic [LEN_W-1:0] rx_len_reg;

	logic             setup;
	logic             wr_en;
	logic             tx_busy;
	logic             rx_busy;

	tx_state_e        tx_state_reg;
	logic [31:0]      sh_reg;
	logic [5:0]       cnt_reg;
	logic [3:0]       rep_reg;
	logic [LEN_W-1:0] oct_reg;
	logic             adv;
	logic [31:0]      long_rev;
	logic [15:0]      short_rev;
	logic [LEN_W-1:0] len_m1;
	logic             phr_long;
	logic [15:0]      phr_word;

	rx_state_e        rx_state_reg;
	logic [15:0]      rx_win_reg;
	logic [4:0]       rx_cnt_reg;
	logic [LEN_W-1:0] rx_left_reg;
	logic [15:0]      win_next;
	logic [LEN_W-1:0] hdr_len;
	logic [4:0]       hdr_last;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Zero wait states: data is picked up in setup, so pready is high
	// in the first access cycle.
	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_o  <= setup;
			pslverr_o <= 1'b0;
			if (setup) begin
				prdata_o <= 32'h0000_0000;
				case (paddr_i)
				CTRL_OFF:     prdata_o[CTRL_HI:CTRL_LO] <= ctrl_reg;
				LENGTH_OFF:   prdata_o[LEN_W-1:0] <= len_reg;
				RX_MAX_OFF:   prdata_o[LEN_W-1:0] <= rx_max_reg;
				DELIM_OFF:    prdata_o[7:0] <= delim_reg;
				LONG_PRE_OFF: prdata_o <= long_pre_reg;
				STATUS_OFF: begin
					prdata_o[STAT_TX_BUSY] <= tx_busy;
					prdata_o[STAT_RX_BUSY] <= rx_busy;
					prdata_o[STAT_RX_ERR]  <= rx_err_reg;
					prdata_o[STAT_LEN_HI:STAT_LEN_LO] <= rx_len_reg;
				end
				default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctrl_reg     <= CTRL_RST;
			len_reg      <= LEN_RST;
			rx_max_reg   <= RX_MAX_RST;
			delim_reg    <= DELIM_RST;
			long_pre_reg <= LONG_PRE_RST;
		end else if (ce_i && wr_en) begin
			case (paddr_i)
			CTRL_OFF: begin
				ctrl_reg <= ctrl_s'(pwdata_i[CTRL_HI:CTRL_LO]);
				if (pwdata_i[REP_HI:REP_LO] > REP_MAX) begin
					ctrl_reg.preamble_pattern_repeat_count <= REP_MAX;
				end
			end
			LENGTH_OFF:   len_reg <= pwdata_i[LEN_W-1:0];
			RX_MAX_OFF:   rx_max_reg <= pwdata_i[LEN_W-1:0];
			DELIM_OFF:    delim_reg <= pwdata_i[7:0];
			LONG_PRE_OFF: long_pre_reg <= pwdata_i;
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			start_reg <= 1'b0;
		end else if (ce_i) begin
			start_reg <= wr_en && paddr_i == CTRL_OFF
				&& pwdata_i[CTRL_TX_START];
		end
	end

	// A new error in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_err_reg <= 1'b0;
		end else if (ce_i) begin
			if (err_pulse_reg) begin
				rx_err_reg <= 1'b1;
			end else if (wr_en && paddr_i == STATUS_OFF
				&& pwdata_i[STAT_RX_ERR]) begin
				rx_err_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit field builder
	// ------------------------------------------------------------
	// Patterns go out in written order, so reverse them once here and
	// the shifter can always send bit 0 first.
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_rev
			assign long_rev[gi] = long_pre_reg[31-gi];
			if (gi < 16) begin : g_short
				assign short_rev[gi] = SHORT_PREAMBLE_PATTERN[15-gi];
			end
		end
	endgenerate

	assign len_m1   = len_reg - 1'b1;
	assign phr_long = len_reg > SHORT_MAX;
	assign phr_word = phr_long ? {len_m1[10:0], 4'h0, 1'b1}
		: {8'h00, len_m1[6:0], 1'b0};
	assign adv      = !tx_bit_valid_o || tx_bit_ready_i;
	assign tx_busy  = tx_state_reg != TX_IDLE || cnt_reg != 6'h00
		|| tx_bit_valid_o;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_state_reg    <= TX_IDLE;
			sh_reg          <= 32'h0000_0000;
			cnt_reg         <= 6'h00;
			rep_reg         <= 4'h0;
			oct_reg         <= '0;
			tx_byte_ready_o <= 1'b0;
			tx_done_o       <= 1'b0;
		end else if (ce_i) begin
			tx_done_o       <= 1'b0;
			tx_byte_ready_o <= tx_state_reg == TX_PAY && cnt_reg == 6'h00
				&& oct_reg != '0 && !(tx_byte_valid_i && tx_byte_ready_o);
			if (cnt_reg != 6'h00) begin
				if (adv) begin
					sh_reg  <= {1'b0, sh_reg[31:1]};
					cnt_reg <= cnt_reg - 6'h01;
				end
			end else begin
				case (tx_state_reg)
				TX_IDLE: begin
					if (start_reg) begin
						tx_state_reg <= TX_PRE;
						rep_reg <= ctrl_reg.preamble_pattern_repeat_count;
						oct_reg <= len_reg;
					end
				end
				TX_PRE: begin
					if (rep_reg != 4'h0) begin
						sh_reg  <= ctrl_reg.long_pre ? long_rev
							: {16'h0000, short_rev};
						cnt_reg <= ctrl_reg.long_pre ? 6'h20 : 6'h10;
						rep_reg <= rep_reg - 4'h1;
					end else begin
						tx_state_reg <= TX_SFD;
					end
				end
				TX_SFD: begin
					if (ctrl_reg.delimiter_present_flag) begin
						sh_reg  <= {24'h00_0000, delim_reg};
						cnt_reg <= 6'h08;
					end
					tx_state_reg <= TX_PHR;
				end
				TX_PHR: begin
					if (!ctrl_reg.fixed) begin
						sh_reg  <= {16'h0000, phr_word};
						cnt_reg <= phr_long ? 6'h10 : 6'h08;
					end
					tx_state_reg <= TX_PAY;
				end
				TX_PAY: begin
					if (oct_reg == '0) begin
						tx_state_reg <= TX_IDLE;
						tx_done_o    <= 1'b1;
					end else if (tx_byte_valid_i && tx_byte_ready_o) begin
						sh_reg  <= {24'h00_0000, tx_byte_i};
						cnt_reg <= 6'h08;
						oct_reg <= oct_reg - 1'b1;
					end
				end
				default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end

	// Every field leaves through this one stage to the modulator
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_bit_o       <= 1'b0;
			tx_bit_valid_o <= 1'b0;
		end else if (ce_i && adv) begin
			tx_bit_o       <= sh_reg[0];
			tx_bit_valid_o <= cnt_reg != 6'h00;
		end
	end

	// ------------------------------------------------------------
	// Receive parser
	// ------------------------------------------------------------
	assign win_next = {rx_bit_i, rx_win_reg[15:1]};
	assign hdr_last = ctrl_reg.long_hdr ? 5'h0F : 5'h07;
	assign hdr_len  = ctrl_reg.long_hdr
		? {1'b0, win_next[15:5]} + 1'b1
		: {5'h00, win_next[15:9]} + 1'b1;
	assign rx_busy  = rx_state_reg == RX_PHR || rx_state_reg == RX_PAY;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_state_reg    <= RX_IDLE;
			rx_win_reg      <= 16'h0000;
			rx_cnt_reg      <= 5'h00;
			rx_left_reg     <= '0;
			rx_len_reg      <= '0;
			rx_byte_o       <= 8'h00;
			rx_byte_valid_o <= 1'b0;
			rx_sync_o       <= 1'b0;
			rx_end_o        <= 1'b0;
			err_pulse_reg   <= 1'b0;
		end else if (ce_i) begin
			rx_byte_valid_o <= 1'b0;
			rx_sync_o       <= 1'b0;
			rx_end_o        <= 1'b0;
			err_pulse_reg   <= 1'b0;
			if (!ctrl_reg.rx_en) begin
				rx_state_reg <= RX_IDLE;
			end else begin
				case (rx_state_reg)
				RX_IDLE: begin
					rx_cnt_reg  <= 5'h00;
					rx_win_reg  <= 16'h0000;
					rx_left_reg <= len_reg;
					rx_len_reg  <= len_reg;
					if (ctrl_reg.delimiter_present_flag) begin
						rx_state_reg <= RX_HUNT;
					end else if (ctrl_reg.fixed) begin
						rx_state_reg <= RX_PAY;
					end else begin
						rx_state_reg <= RX_PHR;
					end
				end
				RX_HUNT: begin
					if (rx_bit_valid_i) begin
						rx_win_reg <= win_next;
						if (rx_cnt_reg != 5'h08) begin
							rx_cnt_reg <= rx_cnt_reg + 5'h01;
						end
						if (rx_cnt_reg >= 5'h07
							&& win_next[15:8] == delim_reg) begin
							rx_sync_o  <= 1'b1;
							rx_cnt_reg <= 5'h00;
							rx_state_reg <= ctrl_reg.fixed ? RX_PAY : RX_PHR;
						end
					end
				end
				RX_PHR: begin
					if (rx_bit_valid_i) begin
						rx_win_reg <= win_next;
						rx_cnt_reg <= rx_cnt_reg + 5'h01;
						if (rx_cnt_reg == 5'h00
							&& rx_bit_i != ctrl_reg.long_hdr) begin
							err_pulse_reg <= 1'b1;
							rx_state_reg  <= RX_IDLE;
						end else if (rx_cnt_reg == hdr_last) begin
							rx_cnt_reg  <= 5'h00;
							rx_len_reg  <= hdr_len;
							rx_left_reg <= hdr_len;
							if (hdr_len > rx_max_reg || (ctrl_reg.long_hdr
								&& hdr_len <= SHORT_MAX)) begin
								err_pulse_reg <= 1'b1;
								rx_state_reg  <= RX_IDLE;
							end else begin
								rx_state_reg <= RX_PAY;
							end
						end
					end
				end
				RX_PAY: begin
					if (rx_left_reg == '0) begin
						rx_end_o     <= 1'b1;
						rx_state_reg <= RX_IDLE;
					end else if (rx_bit_valid_i) begin
						rx_win_reg <= win_next;
						if (rx_cnt_reg == 5'h07) begin
							rx_byte_o       <= win_next[15:8];
							rx_byte_valid_o <= 1'b1;
							rx_cnt_reg      <= 5'h00;
							rx_left_reg     <= rx_left_reg - 1'b1;
						end else begin
							rx_cnt_reg <= rx_cnt_reg + 5'h01;
						end
					end
				end
				default: rx_state_reg <= RX_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Interleaver between coder and spreader
	// ------------------------------------------------------------
	pruned_reverse_interleaver u_interleaver (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.ce_i        (ce_i),
		.frag_sel_i  (ctrl_reg.frag),
		.sym_i       (coded_sym_i),
		.sym_valid_i (coded_valid_i),
		.sym_ready_o (coded_ready_o),
		.sym_o       (intlv_sym_o),
		.sym_valid_o (intlv_valid_o),
		.sym_ready_i (intlv_ready_i)
	);

endmodule

// ===== testbench/framer_asserts.sv
// Port checks for the framer.
// Bound from the testbench; sees ports only.
`timescale 1ns/1ns
module framer_asserts import dsss_framer_pkg::*; (
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              reset_n_i,
	// APB
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [31:0]       pwdata_i,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	// Frame ports
	input wire logic              tx_bit_o,
	input wire logic              tx_bit_valid_o,
	input wire logic              tx_bit_ready_i,
	input wire logic              tx_done_o,
	input wire logic              rx_byte_valid_o,
	input wire logic              rx_sync_o,
	// Interleaver
	input wire logic              coded_valid_i,
	input wire logic              coded_ready_o,
	input wire logic              intlv_sym_o,
	input wire logic              intlv_valid_o,
	input wire logic              intlv_ready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [1:0] frag_reg;
	logic [9:0] fill_reg, size;
	assign size = frag_reg == 2'h0 ? FRAG_256_SYMS
		: frag_reg == 2'h1 ? FRAG_384_SYMS : FRAG_512_SYMS;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			frag_reg <= 2'h0;
		else if (pready_o && pwrite_i && paddr_i == CTRL_OFF)
			frag_reg <= pwdata_i[7:6];
	end
	// Restarts while the buffer drains
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !coded_ready_o)
			fill_reg <= 10'h000;
		else if (coded_valid_i)
			fill_reg <= fill_reg + 10'h001;
	end
	a_apb_no_wait: assert property (
		psel_i && !penable_i |=> pready_o) else $error("late pready");
	a_unmapped_err: assert property (
		pready_o && paddr_i > STATUS_OFF |-> pslverr_o)
		else $error("no slave error");
	a_bit_hold: assert property (
		tx_bit_valid_o && !tx_bit_ready_i |=>
		tx_bit_valid_o && $stable(tx_bit_o)) else $error("tx bit lost");
	a_done_pulse: assert property (
		tx_done_o |=> !tx_done_o) else $error("done too long");
	a_sync_pulse: assert property (
		rx_sync_o |=> !rx_sync_o) else $error("sync too long");
	a_octet_space: assert property (
		rx_byte_valid_o |=> !rx_byte_valid_o [*7])
		else $error("octet too short");
	a_intlv_hold: assert property (
		intlv_valid_o && !intlv_ready_i |=>
		intlv_valid_o && $stable(intlv_sym_o)) else $error("sym lost");
	a_fill_size: assert property (
		fill_reg < size || !coded_ready_o) else $error("overfill");
	a_drain_len: assert property (
		$fell(coded_ready_o) |-> !coded_ready_o [*8] ##[1:1000]
		coded_ready_o) else $error("drain stuck");
	c_tx_frame: cover property (tx_done_o);
	c_rx_sync: cover property (rx_sync_o);
	c_drain: cover property ($fell(coded_ready_o));
endmodule

// ===== testbench/mod_sink.sv
// Modulator and spreader stand-in: ready lines only.
// Assumes the framer holds outputs while ready is low.
`timescale 1ns/1ns
module mod_sink (
	// Clock, reset and pace
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic slow_i,
	// Ready lines
	output logic      tx_bit_ready_o,
	output logic      intlv_ready_o
);
	logic [2:0] pace_reg;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			pace_reg <= 3'h0;
		else
			pace_reg <= pace_reg + 3'h1;
	end
	// Slow pace stalls tx bits in bursts and the interleaver on alternate cycles to exercise the hold paths
	assign tx_bit_ready_o = !slow_i || pace_reg < 3'h5;
	assign intlv_ready_o = !slow_i || pace_reg[0];
endmodule

// ===== testbench/testbench.sv
// Framer bench: APB master, MAC, serial and coder drivers.
// Assumes package, checker and sink compile first.
`timescale 1ns/1ns
module testbench;
	import dsss_framer_pkg::*;
	logic clk_i = 0, reset_n_i = 0, ce_i = 1, psel_i = 0, slow = 0;
	logic penable_i = 0, pwrite_i = 0, tx_byte_valid_i = 1;
	logic rx_bit_i = 0, rx_bit_valid_i = 0, coded_sym_i = 0;
	logic coded_valid_i = 0, pready_o, pslverr_o, tx_byte_ready_o;
	logic tx_done_o, tx_bit_o, tx_bit_valid_o, tx_bit_ready_i;
	logic rx_byte_valid_o, rx_sync_o, rx_end_o, coded_ready_o;
	logic intlv_sym_o, intlv_valid_o, intlv_ready_i, txq[$], iq[$];
	logic [ADDR_W-1:0] paddr_i = 0;
	logic [7:0] tx_byte_i = 0, rx_byte_o, rxq[$];
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	int n_errors = 0, n_compared = 0, n_sync, n_end, mac_idx;
	always #5 clk_i = ~clk_i;
	dsss_ppdu_framer u_dut (.*);
	mod_sink u_sink (.clk_i, .reset_n_i, .slow_i(slow),
		.tx_bit_ready_o(tx_bit_ready_i), .intlv_ready_o(intlv_ready_i));
	always @(posedge clk_i) begin
		if (tx_bit_valid_o === 1'b1 && tx_bit_ready_i === 1'b1)
			txq.push_back(tx_bit_o);
		if (intlv_valid_o === 1'b1 && intlv_ready_i === 1'b1)
			iq.push_back(intlv_sym_o);
		if (rx_byte_valid_o === 1'b1)
			rxq.push_back(rx_byte_o);
		n_sync += int'(rx_sync_o === 1'b1);
		n_end += int'(rx_end_o === 1'b1);
		if (tx_byte_ready_o === 1'b1) begin
			mac_idx <= mac_idx + 1;
			tx_byte_i <= 8'(8'h36 + mac_idx);
		end
	end
	task automatic give_verdict;
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 9);
		rd = pslverr_o === 1'b1 ? 32'hEEEE_EEEE : prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k == 9) begin
			n_errors++;
			give_verdict;
		end
	endtask
	task automatic wait_q(ref logic q[$], input int n);
		int k;
		for (k = 0; k < 30000 && q.size() < n; k++)
			@(posedge clk_i);
		repeat (40) @(posedge clk_i);
		if (k == 30000) begin
			n_errors++;
			give_verdict;
		end
	endtask
	task automatic cmp_q(ref logic q[$], ref logic e[$]);
		chk(32'(q.size()), 32'(e.size()));
		foreach (e[i])
			if (i < q.size())
				chk(32'(q[i]), 32'(e[i]));
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic reg_reset_case;
		logic [7:0] a[6];
		logic [31:0] v[6];
		a = '{CTRL_OFF, LENGTH_OFF, RX_MAX_OFF, DELIM_OFF, LONG_PRE_OFF,
			8'h18};
		v = '{32'h0000_0108, 32'(LEN_RST), 32'(RX_MAX_RST),
			32'(DELIM_RST), LONG_PRE_RST, 32'hEEEE_EEEE};
		foreach (a[i]) begin
			apb(1'b0, a[i], 32'h0);
			chk(rd, v[i]);
		end
	endtask
	task automatic tx_case(input logic [31:0] c, input int len, rep,
		input logic [7:0] dv);
		logic e[$];
		logic [15:0] h;
		h = len > 128 ? {11'(len - 1), 4'h0, 1'b1}
			: 16'({7'(len - 1), 1'b0});
		for (int r = 0; r < rep * 16; r++)
			e.push_back(SHORT_PREAMBLE_PATTERN[15 - r % 16]);
		for (int b = 0; b < 8 * c[3]; b++)
			e.push_back(dv[b]);
		for (int b = 0; b < (c[2] ? 0 : len > 128 ? 16 : 8); b++)
			e.push_back(h[b]);
		for (int b = 0; b < 8 * len; b++)
			e.push_back(1'((8'h35 + b / 8) >> (b % 8)));
		apb(1'b1, DELIM_OFF, 32'(dv));
		apb(1'b1, LENGTH_OFF, 32'(len));
		mac_idx <= 0;
		tx_byte_i <= 8'h35;
		txq.delete();
		apb(1'b1, CTRL_OFF, c | 32'h1);
		wait_q(txq, e.size());
		cmp_q(txq, e);
	endtask
	task automatic send(input logic [7:0] v);
		for (int b = 0; b < 8; b++) begin
			@(posedge clk_i);
			rx_bit_i <= v[b];
			rx_bit_valid_i <= 1'b1;
		end
	endtask
	task automatic rx_case(input logic [7:0] hdr, input logic [31:0] rmax,
		input logic err);
		apb(1'b1, RX_MAX_OFF, rmax);
		apb(1'b1, DELIM_OFF, 32'h0000_003C);
		apb(1'b1, CTRL_OFF, 32'h0000_010A);
		rxq.delete();
		n_sync = 0;
		n_end = 0;
		send(8'h00);
		send(8'h3C);
		send(hdr);
		for (int i = 1; i < 4; i++)
			send(8'(8'h11 * i));
		@(posedge clk_i);
		rx_bit_valid_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk(32'(n_sync), 32'h0000_0001);
		chk(32'(n_end), 32'(!err));
		chk(32'(rxq.size()), err ? 32'h0 : 32'h3);
		foreach (rxq[i])
			chk(32'(rxq[i]), 32'(8'h11 * (i + 1)));
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd & 32'h4, 32'(err) << 2);
		apb(1'b1, STATUS_OFF, 32'h0000_0004);
	endtask
	function automatic logic sym(int k);
		return ^(k & 32'h16B) ^ (k % 3 == 0);
	endfunction
	task automatic intlv_case(input logic [1:0] f, input int n, w);
		logic e[$];
		int k;
		for (int m = 0; m < (1 << w); m++) begin
			k = 0;
			for (int b = 0; b < w; b++)
				k |= ((m >> b) & 1) << (w - 1 - b);
			if (k < n)
				e.push_back(sym(k));
		end
		apb(1'b1, CTRL_OFF, 32'(f) << 6);
		iq.delete();
		for (int i = 0; i < n; i++) begin
			coded_sym_i <= sym(i);
			coded_valid_i <= 1'b1;
			k = 0;
			do begin
				@(posedge clk_i);
				k++;
			end while (coded_ready_o !== 1'b1 && k < 2000);
		end
		coded_valid_i <= 1'b0;
		wait_q(iq, e.size());
		cmp_q(iq, e);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		reg_reset_case;
		tx_case(32'h0000_0108, 2, 1, 8'hA7);
		tx_case(32'h0000_0004, 3, 0, 8'hA7);
		tx_case(32'h0000_0908, 1, 8, 8'h96);
		slow <= 1'b1;
		tx_case(32'h0000_0208, 129, 2, 8'h5C);
		intlv_case(2'h0, 256, 8);
		slow <= 1'b0;
		intlv_case(2'h1, 384, 9);
		intlv_case(2'h2, 512, 9);
		rx_case(8'h04, 32'h0000_0800, 1'b0);
		rx_case(8'h01, 32'h0000_0800, 1'b1);
		rx_case(8'h04, 32'h0000_0002, 1'b1);
		give_verdict;
	end
endmodule
bind dsss_ppdu_framer framer_asserts u_chk (.*);
